// >>> bench/hrps_far_model.sv
// Far-side model: shared test pin with pull-up, IRQ and strap levels.
// Assumes the bench changes its commands just after rising clock edges.
`timescale 1ns/1ps
module hrps_far_model (
  // Commands from the bench
  input  wire logic       pin_req,
  input  wire logic [3:0] irq_lvl,
  input  wire logic [1:0] strap_lvl,
  // Pins toward the device
  output logic            test_mode_input_n,
  output logic [3:0]      irq_in,
  output logic [1:0]      strap_in
);
  // A released pin returns to the pull-up level, never a stale low
  assign test_mode_input_n = pin_req ? 1'b0 : 1'b1;
  // Board levels; the device filters them, so no edge timing matters
  assign irq_in   = irq_lvl;
  assign strap_in = strap_lvl;
endmodule : hrps_far_model

// >>> bench/tb_hard_reset_pin_state_control.sv
// Self-checking bench for the hard reset and pin state controller.
// Assumes a 100 MHz clock and a shortened software reset hold.
`timescale 1ns/1ps
module tb_hard_reset_pin_state_control;
  localparam int HOLD = 20;
  logic       core_clk = 1'b0, rst_n = 1'b0, power_good = 1'b1;
  logic       pin_req = 1'b0, cfg_req = 1'b0, cfg_wr = 1'b0;
  logic       fn_oe = 1'b1, fn_aen = 1'b0;
  logic [3:0] irq_lvl = 4'h9;
  logic [1:0] strap = 2'b01;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, rd;
  logic       cfg_ack, tmi_n, ale, spk, aen, pr, hbr_n, xr, hra, hoe, poe;
  logic [3:0] irq_in, stb_n, cs_n, sel;
  logic [1:0] strap_in;
  logic [6:0] dack_n;
  logic       ten, flush;
  int         err_count = 0, checked = 0, n;

  // Clock
  always #5 core_clk = ~core_clk;

  hrps_far_model i_far (.pin_req(pin_req), .irq_lvl(irq_lvl),
    .strap_lvl(strap), .test_mode_input_n(tmi_n), .irq_in(irq_in),
    .strap_in(strap_in));

  // Normal function levels differ from every reset level on purpose except aen, which is 0 in both
  hrps_top #(.HOLD_CYC(HOLD)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .power_good(power_good), .test_mode_input_n(tmi_n), .irq_in(irq_in),
    .strap_in(strap_in), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .fn_oe(fn_oe), .fn_strobe_n(4'h5),
    .fn_cs_n(4'ha), .fn_ale(1'b1), .fn_spkr(1'b1), .fn_aen(fn_aen),
    .fn_dack_n(7'h2a), .processor_reset(pr), .host_bus_reset_n(hbr_n),
    .expansion_bus_reset(xr), .hard_reset_active(hra),
    .host_bus_oe(hoe), .par_oe(poe), .strobe_n(stb_n), .cs_n(cs_n),
    .addr_latch(ale), .speaker(spk), .aen(aen), .dack_n(dack_n),
    .test_mode_en(ten), .test_mode_sel(sel), .intc_flush_request(flush));

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // Drive 1 ns after the edge so the design never races the bench
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    cfg_req = 1'b1;
    cfg_wr = w;
    cfg_addr = a;
    cfg_wdata = d;
    tick(1);
    cfg_req = 1'b0;
    i = 0;
    while (cfg_ack !== 1'b1 && i < 4) begin
      tick(1);
      i++;
    end
    if (i == 4) begin
      err_count++;
      conclude();
    end
    rd = cfg_rdata;
    tick(1);
  endtask : cfg

  task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
    cfg(1'b0, a, 8'h00);
    chk_val({24'h0, rd}, {24'h0, exp});
  endtask : rd8

  // Bounded wait for the hard reset state to reach a level
  task automatic wait_hr(input logic lvl);
    int i;
    i = 0;
    while (hra !== lvl && i < 40) begin
      tick(1);
      i++;
    end
    if (i == 40) begin
      err_count++;
      conclude();
    end
  endtask : wait_hr

  function automatic logic [31:0] pins();
    return {9'h0, pr, hbr_n, xr, hoe, poe, ale, spk, aen, stb_n, cs_n, dack_n};
  endfunction : pins

  function automatic logic [31:0] in_rst(input logic [1:0] s);
    return {9'h0, 8'b1010_0000 | {7'h0, s[0]}, 8'hff, {7{s[1]}}};
  endfunction : in_rst

  localparam logic [31:0] RUN = {9'h0, 8'b0101_1110, 8'h5a, 7'h2a};

  task automatic t_power_on();
    tick(5);
    // Under rst_n the strap is not yet filtered, so aen/dack take constants
    chk_val(pins(), in_rst(2'b10));
    rst_n = 1'b1;
    wait_hr(1'b0);
    tick(2);
    chk_val(pins(), RUN);
  endtask : t_power_on

  task automatic t_access();
    rd8(8'h00, 8'h5a);
    cfg(1'b1, 8'h00, 8'hff);
    rd8(8'h00, 8'h5a);
    cfg(1'b1, 8'h10, 8'h77);
    rd8(8'h10, 8'h00);
    rd8(8'h50, 8'h00);
    chk_val({31'h0, hra}, 32'h0);
    rd8(8'h4e, 8'h30);
    cfg(1'b1, 8'h4e, (rd & 8'hf0) | 8'hce);
    rd8(8'h4e, 8'h3e);
    cfg(1'b1, 8'h4e, 8'h30);
    // Outside reset the pins follow the function levels
    fn_oe = 1'b0;
    fn_aen = 1'b1;
    tick(2);
    chk_val(pins(), {9'h0, 8'b0100_0111, 8'h5a, 7'h2a});
    fn_oe = 1'b1;
    fn_aen = 1'b0;
  endtask : t_access

  task automatic t_test_pin();
    pin_req = 1'b1;
    tick(8);
    chk_val({ten, sel, flush}, {1'b1, 4'h9, 1'b0});
    cfg(1'b1, 8'h4e, 8'h31);
    tick(8);
    chk_val({ten, sel, flush}, {1'b0, 4'h0, 1'b1});
    pin_req = 1'b0;
    tick(8);
    chk_val({ten, sel, flush}, 6'h00);
  endtask : t_test_pin

  task automatic t_sw_reset();
    // Strap levels opposite to the rst_n constants, so is visible
    strap = 2'b01;
    cfg(1'b1, 8'h6a, 8'h03);
    rd8(8'h6a, 8'h00);
    cfg(1'b1, 8'h50, 8'h02);
    wait_hr(1'b1);
    n = 0;
    while (hra === 1'b1 && n < 100) begin
      if (n == 8) begin
        chk_val(pins(), in_rst(2'b01));
      end
      tick(1);
      n++;
    end
    // Reset rose at the taking edge, one cycle before cfg returned
    chk_val(n + 1, HOLD);
    rd8(8'h4e, 8'h30);
    rd8(8'h6a, 8'h02);
    cfg(1'b1, 8'h6a, 8'h00);
    rd8(8'h6a, 8'h02);
    cfg(1'b1, 8'h6a, 8'h02);
    rd8(8'h6a, 8'h00);
    pin_req = 1'b1;
    tick(8);
    chk_val({ten, sel, flush}, {1'b1, 4'h9, 1'b0});
    pin_req = 1'b0;
  endtask : t_sw_reset

  task automatic t_pg_drop();
    strap = 2'b10;
    power_good = 1'b0;
    wait_hr(1'b1);
    tick(3);
    chk_val(pins(), in_rst(2'b10));
    power_good = 1'b1;
    wait_hr(1'b0);
    tick(1);
    chk_val(pins(), RUN);
    cfg(1'b0, 8'h6a, 8'h00);
    chk_val({31'h0, rd[0]}, 32'h1);
  endtask : t_pg_drop

  // Main sequence: reset held 8 cycles, 3 here and 5 in t_power_on's first ticks
  initial begin
    #1;
    tick(3);
    t_power_on();
    t_access();
    t_test_pin();
    t_sw_reset();
    t_pg_drop();
    conclude();
  end
endmodule : tb_hard_reset_pin_state_control

// >>> design/hrps_top.sv
// Hard reset sequencer, pin reset levels, test input and config regs.
// Assumes pins are asynchronous and fn_* and cfg_* are on core_clk.
//
// Behaviour
// - Shared pin is test input after reset
// - Test mode from test input and IRQs
// - Hard reset on power-good or software
// - Pins take fixed levels during hard reset
// - AEN and DACK reset levels from strap, but 0 and all ones while rst_n is low
// - Hard reset loads register defaults
// - Reserved config locations still complete cycle
// - Read-only registers ignore writes
// - Reads of write-only registers change nothing
// - Read-only bits in R/W register ignore writes
// - Write one clears, write zero keeps
// - Resets follow power-good level
// - Software hard reset holds bus reset 1 ms
`timescale 1ns/1ps
`include "hrps_defines.svh"

module hrps_top
  import hrps_pkg::*;
#(
  parameter int HOLD_CYC = `HRPS_SW_HOLD_CYC,
  parameter int IRQ_W    = 4,
  parameter int STB_W    = 4,
  parameter int CS_W     = 4,
  parameter int DACK_W   = 7
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Asynchronous pins
  input  wire logic              power_good,
  input  wire logic              test_mode_input_n,
  input  wire logic [IRQ_W-1:0]  irq_in,
  input  wire logic [1:0]        strap_in,
  // Config access
  input  wire logic              cfg_req,
  input  wire logic              cfg_wr,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [7:0]        cfg_wdata,
  output logic                   cfg_ack,
  output logic [7:0]             cfg_rdata,
  // Normal function drive
  input  wire logic              fn_oe,
  input  wire logic [STB_W-1:0]  fn_strobe_n,
  input  wire logic [CS_W-1:0]   fn_cs_n,
  input  wire logic              fn_ale,
  input  wire logic              fn_spkr,
  input  wire logic              fn_aen,
  input  wire logic [DACK_W-1:0] fn_dack_n,
  // Reset outputs
  output logic                   processor_reset,
  output logic                   host_bus_reset_n,
  output logic                   expansion_bus_reset,
  output logic                   hard_reset_active,
  // Pin drive
  output logic                   host_bus_oe,
  output logic                   par_oe,
  output logic [STB_W-1:0]       strobe_n,
  output logic [CS_W-1:0]        cs_n,
  output logic                   addr_latch,
  output logic                   speaker,
  output logic                   aen,
  output logic [DACK_W-1:0]      dack_n,
  // Test and interrupt-controller use of the shared pin
  output logic                   test_mode_en,
  output logic [IRQ_W-1:0]       test_mode_sel,
  output logic                   intc_flush_request
);

  localparam int SW = IRQ_W + 4;
  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam logic [SW-1:0] SYNC_INIT = SW'(2);  // Test pin idles high

  generate
    if (HOLD_CYC < 1 || IRQ_W < 1) begin : g_bad_param
      $error("hrps_top: HOLD_CYC and IRQ_W must be at least 1");
    end
  endgenerate

  // Three-stage synchronisers; value moves when stages two and three agree
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] s1_r, s2_r, s3_r, f_r, f_nxt;
  assign pin_raw = {irq_in, strap_in, test_mode_input_n, power_good};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      always_comb begin
        f_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : f_r[gi];
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[gi] <= SYNC_INIT[gi];
          s2_r[gi] <= SYNC_INIT[gi];
          s3_r[gi] <= SYNC_INIT[gi];
          f_r[gi]  <= SYNC_INIT[gi];
        end else begin
          s1_r[gi] <= pin_raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          f_r[gi]  <= f_nxt[gi];
        end
      end
    end
  endgenerate

  logic             pg_f, test_n_f;
  logic [1:0]       strap_f;
  logic [IRQ_W-1:0] irq_f;
  assign pg_f     = f_r[0];
  assign test_n_f = f_r[1];
  assign strap_f  = f_r[3:2];
  assign irq_f    = f_r[SW-1:4];

  // Config decode
  logic wr_xcs, wr_rctl, wr_cause, sw_req;
  assign wr_xcs   = cfg_req && cfg_wr && cfg_addr == `HRPS_OFS_XCS;
  assign wr_rctl  = cfg_req && cfg_wr && cfg_addr == `HRPS_OFS_RCTL;
  assign wr_cause = cfg_req && cfg_wr && cfg_addr == `HRPS_OFS_CAUSE;
  assign sw_req   = wr_rctl && cfg_wdata[`HRPS_RCTL_HARD];

  // Hard reset sequencer; power-good loss overrides a software hold
  hrps_state_t   st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          hard;
  assign hard = (st_r != HR_IDLE);

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = '0;
    unique case (st_r)
      HR_IDLE: begin
        if (!pg_f) st_nxt = HR_PWR;
        else if (sw_req) st_nxt = HR_SW;
      end
      HR_PWR: begin
        if (pg_f) st_nxt = HR_IDLE;
      end
      HR_SW: begin
        cnt_nxt = cnt_r + CW'(1);
        if (!pg_f) st_nxt = HR_PWR;
        else if (cnt_r == CW'(HOLD_CYC - 1)) st_nxt = HR_IDLE;
      end
      default: st_nxt = HR_PWR;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= HR_PWR;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Config registers; defaults reload for the whole hard reset
  logic [7:0] xcs_r, xcs_nxt, cause_r, cause_nxt, rdata_nxt;
  logic       ack_nxt;

  always_comb begin
    xcs_nxt   = xcs_r;
    cause_nxt = cause_r;
    if (hard) begin
      xcs_nxt   = `HRPS_XCS_RST;
      cause_nxt = `HRPS_CAUSE_RST;
    end else begin
      if (wr_xcs)
        xcs_nxt = (xcs_r & `HRPS_XCS_RO) | (cfg_wdata & ~`HRPS_XCS_RO);
      if (wr_cause) cause_nxt = cause_r & ~cfg_wdata;
    end
    // Setting beats a clear in the same cycle
    if (st_r == HR_PWR && st_nxt == HR_IDLE)
      cause_nxt[`HRPS_CAUSE_PWR] = 1'b1;
    if (st_r == HR_SW && st_nxt == HR_IDLE)
      cause_nxt[`HRPS_CAUSE_SW] = 1'b1;
    // Every location answers; reserved and write-only read zero
    ack_nxt   = cfg_req;
    rdata_nxt = 8'h00;
    if (cfg_req && !cfg_wr) begin
      unique case (cfg_addr)
        `HRPS_OFS_ID:    rdata_nxt = `HRPS_ID_VAL;
        `HRPS_OFS_XCS:   rdata_nxt = xcs_r;
        `HRPS_OFS_CAUSE: rdata_nxt = cause_r;
        default:         rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xcs_r     <= `HRPS_XCS_RST;
      cause_r   <= `HRPS_CAUSE_RST;
      cfg_ack   <= 1'b0;
      cfg_rdata <= 8'h00;
    end else begin
      xcs_r     <= xcs_nxt;
      cause_r   <= cause_nxt;
      cfg_ack   <= ack_nxt;
      cfg_rdata <= rdata_nxt;
    end
  end

  // Output pins; computed from next state so they move with the reset
  logic              hard_nxt, intc_mode;
  logic [STB_W-1:0]  stb_nxt;
  logic [CS_W-1:0]   cs_nxt;
  logic [DACK_W-1:0] dack_nxt;
  logic [IRQ_W-1:0]  tsel_nxt;
  logic              oe_nxt, par_nxt, ale_nxt, spk_nxt, aen_nxt;
  logic              ten_nxt, flush_nxt;
  assign intc_mode = xcs_nxt[`HRPS_XCS_INTC];

  always_comb begin
    hard_nxt  = (st_nxt != HR_IDLE);
    oe_nxt    = hard_nxt ? 1'b0 : fn_oe;
    par_nxt   = hard_nxt ? 1'b0 : fn_oe;
    stb_nxt   = hard_nxt ? '1 : fn_strobe_n;
    cs_nxt    = hard_nxt ? '1 : fn_cs_n;
    ale_nxt   = hard_nxt ? 1'b0 : fn_ale;
    spk_nxt   = hard_nxt ? 1'b0 : fn_spkr;
    aen_nxt   = hard_nxt ? strap_f[0] : fn_aen;
    dack_nxt  = hard_nxt ? {DACK_W{strap_f[1]}} : fn_dack_n;
    // Pin is the test input unless the interrupt-controller bit is set
    ten_nxt   = !intc_mode && !test_n_f;
    tsel_nxt  = ten_nxt ? irq_f : '0;
    flush_nxt = intc_mode && !test_n_f;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      processor_reset     <= 1'b1;
      host_bus_reset_n    <= 1'b0;
      expansion_bus_reset <= 1'b1;
      hard_reset_active   <= 1'b1;
      host_bus_oe         <= 1'b0;
      par_oe              <= 1'b0;
      strobe_n            <= '1;
      cs_n                <= '1;
      addr_latch          <= 1'b0;
      speaker             <= 1'b0;
      aen                 <= 1'b0;
      dack_n              <= '1;
      test_mode_en        <= 1'b0;
      test_mode_sel       <= '0;
      intc_flush_request  <= 1'b0;
    end else begin
      processor_reset     <= hard_nxt;
      host_bus_reset_n    <= !hard_nxt;
      expansion_bus_reset <= hard_nxt;
      hard_reset_active   <= hard_nxt;
      host_bus_oe         <= oe_nxt;
      par_oe              <= par_nxt;
      strobe_n            <= stb_nxt;
      cs_n                <= cs_nxt;
      addr_latch          <= ale_nxt;
      speaker             <= spk_nxt;
      aen                 <= aen_nxt;
      dack_n              <= dack_nxt;
      test_mode_en        <= ten_nxt;
      test_mode_sel       <= tsel_nxt;
      intc_flush_request  <= flush_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_pg_low_resets: assert property (!pg_f |=> processor_reset &&
      !host_bus_reset_n && expansion_bus_reset)
    else $error("resets not held while power-good low");
  a_pg_release: assert property (st_r == HR_PWR && pg_f |=>
      !processor_reset && host_bus_reset_n && !expansion_bus_reset)
    else $error("resets not released after power-good");
  a_sw_start: assert property (st_r == HR_IDLE && pg_f && sw_req
      |=> st_r == HR_SW ##0 !host_bus_reset_n)
    else $error("software hard reset not started");
  a_sw_hold_len: assert property (st_r == HR_SW && st_nxt == HR_IDLE
      |-> cnt_r == CW'(HOLD_CYC - 1))
    else $error("software reset hold length wrong");
  a_pin_levels: assert property (hard_reset_active |-> &strobe_n &&
      &cs_n && !addr_latch && !speaker && !host_bus_oe && !par_oe)
    else $error("pin level wrong during hard reset");
  a_strap_aen: assert property (hard_reset_active && $past(rst_n)
      |-> aen == $past(strap_f[0]) && dack_n == {DACK_W{$past(strap_f[1])}})
    else $error("strap level not driven during hard reset");
  a_reg_default: assert property (hard |=> xcs_r == `HRPS_XCS_RST)
    else $error("register default not loaded");
  a_test_input: assert property (!xcs_nxt[`HRPS_XCS_INTC] && !test_n_f
      |=> test_mode_en && test_mode_sel == $past(irq_f))
    else $error("test mode not selected");
  a_cfg_ack: assert property (cfg_req |=> cfg_ack)
    else $error("config cycle not completed");
  a_ro_id: assert property (cfg_req && !cfg_wr &&
      cfg_addr == `HRPS_OFS_ID |=> cfg_rdata == `HRPS_ID_VAL)
    else $error("read-only register changed");
  a_wo_read: assert property (cfg_req && !cfg_wr && st_r == HR_IDLE &&
      pg_f && cfg_addr == `HRPS_OFS_RCTL |=> cfg_rdata == 8'h00 &&
      st_r == HR_IDLE)
    else $error("write-only read had an effect");
  a_ro_bits: assert property (!hard ##1 !hard |->
      (xcs_r & `HRPS_XCS_RO) == ($past(xcs_r) & `HRPS_XCS_RO))
    else $error("read-only bits changed");
  a_w1c: assert property (!hard && wr_cause &&
      cfg_wdata[`HRPS_CAUSE_PWR] && st_r != HR_PWR
      |=> !cause_r[`HRPS_CAUSE_PWR])
    else $error("write one did not clear");

endmodule : hrps_top

// >>> include/hrps_defines.svh
// Constants for the hard reset and pin state controller.
// Assumes a 100 MHz core clock; offsets are config byte addresses.
`ifndef HRPS_DEFINES_SVH
`define HRPS_DEFINES_SVH

// Timing
`define HRPS_CLK_PERIOD_NS  10
`define HRPS_SW_HOLD_NS     1000000
`define HRPS_SW_HOLD_CYC \
  ((`HRPS_SW_HOLD_NS + `HRPS_CLK_PERIOD_NS - 1) / `HRPS_CLK_PERIOD_NS)

// Config offsets
`define HRPS_OFS_ID     8'h00
`define HRPS_OFS_XCS    8'h4e
`define HRPS_OFS_RCTL   8'h50
`define HRPS_OFS_CAUSE  8'h6a

// Reset values and fields
`define HRPS_ID_VAL     8'h5a
`define HRPS_XCS_RST    8'h30
`define HRPS_XCS_RO     8'hf0
`define HRPS_XCS_INTC   0
`define HRPS_RCTL_HARD  1
`define HRPS_CAUSE_RST  8'h00
`define HRPS_CAUSE_PWR  0
`define HRPS_CAUSE_SW   1

`endif

// >>> include/hrps_pkg.sv
// Types for the hard reset and pin state controller.
// Used together with hrps_defines.svh.
package hrps_pkg;
  typedef enum logic [1:0] {
    HR_IDLE = 2'b00,
    HR_PWR  = 2'b01,
    HR_SW   = 2'b10
  } hrps_state_t;
endpackage : hrps_pkg
